// >>> hdl/tpm_pkg.sv
// tpm_pkg: constants for the thread scratch word and page size mask registers.
// assumes a core pipeline that issues coprocessor moves and translation-buffer strobes.
//
// Summary of operation
// - the thread scratch word is a plain 32-bit read-write word that hardware never interprets.
// - hardware register read index 29 returns the scratch word to user code only when enable bit 29 is set.
// - the page size mask stages the entry mask for translation-buffer writes and reads.
// - mask bits 28:13 set to one drop the matching address bits from the match compare.
// - with small pages capable and enabled, bits 12:11 are read-write, reset to zero and copied to and from entries.
// - otherwise bits 12:11 ignore writes, read zero, and an entry write stores them as binary 11.
// - in a first-release build bits 12:11 read zero and never touch translation.
// - bits 31:29 and 10:0 drop writes and read zero.
// - page size is a thermometer of bit pairs from 4 KB (bits 12:11) up to 256 MB (bits 28:11).
// - the 4 KB size is always supported; larger sizes are build options.
// - bits of unimplemented sizes read as zero even after software wrote ones.
// - the small-page enable bit of the page granularity control resets to zero and gates 1 KB support.
package tpm_pkg;
   // ---------------------------------------------------------------
   // register selects for the coprocessor move port
   // ---------------------------------------------------------------
   localparam logic [1:0] TPM_SEL_SCRATCH = 2'h0;
   localparam logic [1:0] TPM_SEL_PMASK = 2'h1;
   localparam logic [1:0] TPM_SEL_GRAIN = 2'h2;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int TPM_MASK_LSB = 13;
   localparam int TPM_MASK_MSB = 28;
   localparam int TPM_MASK_EXT_LSB = 11;
   localparam int TPM_MASK_EXT_MSB = 12;
   localparam int TPM_NUM_SIZES = 8;
   localparam logic [4:0] TPM_USER_LOCAL_INDEX = 5'h1d;
   localparam int TPM_HW_READ_EN_BIT = 29;
   localparam int TPM_GRAIN_SPE_BIT = 28;

   // ---------------------------------------------------------------
   // reset values and fixed patterns
   // ---------------------------------------------------------------
   localparam logic [1:0] TPM_MASK_EXT_RESET = 2'h0;
   localparam logic [1:0] TPM_MASK_EXT_FORCED = 2'h3;
   localparam logic [15:0] TPM_MASK_RESET = 16'h0000;
   localparam logic [31:0] TPM_SCRATCH_RESET = 32'h0000_0000;
   localparam logic TPM_SPE_RESET = 1'b0;
endpackage : tpm_pkg

// >>> hdl/tpm_size_filter.sv
// tpm_size_filter: clears mask bit pairs of page sizes the build does not implement.
// assumes the enable vector is a static build parameter.
`timescale 1ns/10ps
module tpm_size_filter
   import tpm_pkg::*;
#(
   parameter logic [7:0] SIZE_EN = 8'hff
) (
   // raw mask field
   input wire logic [15:0] mask_in,
   // filtered mask field
   output logic [15:0] mask_out
);
   genvar g;
   generate
      for (g = 0; g < TPM_NUM_SIZES; g++) begin : g_pair
         // pair g covers 16 KB << 2g; 4 KB lives in bits 12:11 and is always kept
         assign mask_out[2*g+1 -: 2] = SIZE_EN[g] ? mask_in[2*g+1 -: 2] : 2'h0;
      end
   endgenerate
endmodule // tpm_size_filter

// >>> hdl/tpm_regs.sv
// tpm_regs: scratch word and page size mask registers with entry staging.
// assumes the pipeline gives one-cycle write and entry strobes, sync to core_clk_in.
`timescale 1ns/10ps
module tpm_regs
   import tpm_pkg::*;
#(
   parameter logic [7:0] SIZE_EN = 8'hff,   // 16 KB .. 256 MB support, bit 0 = 16 KB
   parameter bit RELEASE2 = 1'b1,
   parameter bit SMALL_PAGE_CAPABLE = 1'b1
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // privileged coprocessor moves
   input wire logic cop_wr_en_in,
   input wire logic [1:0] cop_sel_in,
   input wire logic [31:0] cop_wr_data_in,
   output logic [31:0] cop_rd_data_out,
   // hardware register read instruction
   input wire logic hwr_rd_en_in,
   input wire logic [4:0] hwr_index_in,
   input wire logic [31:0] hw_read_enable_reg_in,
   input wire logic user_mode_in,
   output logic [31:0] hwr_rd_data_out,
   output logic hwr_rd_ok_out,
   // translation-buffer entry staging
   input wire logic tlb_read_en_in,
   input wire logic [17:0] tlb_entry_mask_in,
   output logic [17:0] tlb_write_mask_out,
   output logic small_page_enable_out
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [31:0] scratch;
      logic [15:0] mask;
      logic [1:0] mask_ext;
      logic spe;
      logic [31:0] cop_rd;
      logic [31:0] hwr_rd;
      logic hwr_ok;
   } tpm_state_t;

   tpm_state_t state_reg;
   tpm_state_t state_next;
   logic [15:0] mask_wr_filt;
   logic [15:0] mask_rd_filt;
   logic small_on;
   logic [31:0] pmask_view;

   // ---------------------------------------------------------------
   // size filters: one on writes, one on entry reads
   // ---------------------------------------------------------------
   tpm_size_filter #(.SIZE_EN(SIZE_EN)) u_filt_wr (
      .mask_in(cop_wr_data_in[TPM_MASK_MSB:TPM_MASK_LSB]),
      .mask_out(mask_wr_filt)
   );
   tpm_size_filter #(.SIZE_EN(SIZE_EN)) u_filt_rd (
      .mask_in(tlb_entry_mask_in[17:2]),
      .mask_out(mask_rd_filt)
   );

   // first-release builds never expose the extension field
   assign small_on = RELEASE2 && SMALL_PAGE_CAPABLE && state_reg.spe;

   always_comb begin
      pmask_view = 32'h0000_0000;
      pmask_view[TPM_MASK_MSB:TPM_MASK_LSB] = state_reg.mask;
      pmask_view[TPM_MASK_EXT_MSB:TPM_MASK_EXT_LSB] =
         small_on ? state_reg.mask_ext : 2'h0;
   end

   always_comb begin
      state_next = state_reg;
      state_next.hwr_ok = 1'b0;
      if (cop_wr_en_in) begin
         case (cop_sel_in)
            TPM_SEL_SCRATCH: begin
               state_next.scratch = cop_wr_data_in;
            end
            TPM_SEL_PMASK: begin
               // unimplemented sizes are dropped here so read-back shows zero
               state_next.mask = mask_wr_filt;
               if (small_on) begin
                  state_next.mask_ext =
                     cop_wr_data_in[TPM_MASK_EXT_MSB:TPM_MASK_EXT_LSB];
               end
            end
            TPM_SEL_GRAIN: begin
               // no flush here: entries keep stale granularity if software skips it
               state_next.spe = cop_wr_data_in[TPM_GRAIN_SPE_BIT];
            end
            default: begin
            end
         endcase
      end
      if (tlb_read_en_in) begin
         state_next.mask = mask_rd_filt;
         if (small_on) begin
            state_next.mask_ext = tlb_entry_mask_in[1:0];
         end
      end
      case (cop_sel_in)
         TPM_SEL_SCRATCH: state_next.cop_rd = state_reg.scratch;
         TPM_SEL_PMASK: state_next.cop_rd = pmask_view;
         TPM_SEL_GRAIN: state_next.cop_rd = {3'h0, state_reg.spe, 28'h0000000};
         default: state_next.cop_rd = 32'h0000_0000;
      endcase
      state_next.hwr_rd = 32'h0000_0000;
      if (hwr_rd_en_in && hwr_index_in == TPM_USER_LOCAL_INDEX
            && (!user_mode_in || hw_read_enable_reg_in[TPM_HW_READ_EN_BIT])) begin
         state_next.hwr_rd = state_reg.scratch;
         state_next.hwr_ok = 1'b1;
      end
   end

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg.scratch <= TPM_SCRATCH_RESET;
         state_reg.mask <= TPM_MASK_RESET;
         state_reg.mask_ext <= TPM_MASK_EXT_RESET;
         state_reg.spe <= TPM_SPE_RESET;
         state_reg.cop_rd <= 32'h0000_0000;
         state_reg.hwr_rd <= 32'h0000_0000;
         state_reg.hwr_ok <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign cop_rd_data_out = state_reg.cop_rd;
   assign hwr_rd_data_out = state_reg.hwr_rd;
   assign hwr_rd_ok_out = state_reg.hwr_ok;
   assign small_page_enable_out = small_on;
   // entry write: forced 11 when small pages are off, so 4 KB stays the floor
   assign tlb_write_mask_out = {state_reg.mask,
      small_on ? state_reg.mask_ext : TPM_MASK_EXT_FORCED};
endmodule // tpm_regs

// >>> dv/tpm_regs_sva.sv
// tpm_regs_sva: port checks for the scratch word and page size mask registers.
// assumes it is bound onto tpm_regs, one clock, async active-low reset.
`timescale 1ns/10ps
module tpm_regs_sva
   import tpm_pkg::*;
#(parameter logic [7:0] SIZE_EN = 8'hff, parameter bit RELEASE2 = 1'b1,
   parameter bit SMALL_PAGE_CAPABLE = 1'b1) (
   input wire logic core_clk_in, reset_n_in, cop_wr_en_in, hwr_rd_en_in, user_mode_in,
   input wire logic tlb_read_en_in, hwr_rd_ok_out, small_page_enable_out,
   input wire logic [1:0] cop_sel_in,
   input wire logic [4:0] hwr_index_in,
   input wire logic [31:0] cop_wr_data_in, cop_rd_data_out,
   input wire logic [31:0] hw_read_enable_reg_in, hwr_rd_data_out,
   input wire logic [17:0] tlb_entry_mask_in, tlb_write_mask_out);
   logic [15:0] keep;
   always_comb for (int g = 0; g < 8; g++) keep[2*g +: 2] = {2{SIZE_EN[g]}};
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   sequence scr_wr; cop_wr_en_in && cop_sel_in == TPM_SEL_SCRATCH; endsequence
   sequence scr_rd; cop_sel_in == TPM_SEL_SCRATCH && !cop_wr_en_in; endsequence
   scr_back_a: assert property (scr_wr ##1 scr_rd |=>
      cop_rd_data_out == $past(cop_wr_data_in, 2)) else $error("scratch read-back wrong");
   pm_zero_a: assert property ($past(cop_sel_in) == TPM_SEL_PMASK |->
      cop_rd_data_out[31:29] == 3'h0 && cop_rd_data_out[10:0] == 11'h0) else $error("pm zeros");
   mx_hide_a: assert property ($past(cop_sel_in) == TPM_SEL_PMASK &&
      !$past(small_page_enable_out) |-> cop_rd_data_out[12:11] == 2'h0) else $error("mx shown");
   tlb_forced_a: assert property (!small_page_enable_out |->
      tlb_write_mask_out[1:0] == TPM_MASK_EXT_FORCED) else $error("mx not forced");
   unimpl_zero_a: assert property ((tlb_write_mask_out[17:2] & ~keep) == 16'h0)
      else $error("unimplemented size kept");
   mx_copy_a: assert property (tlb_read_en_in && small_page_enable_out &&
      !cop_wr_en_in |=> tlb_write_mask_out == ($past(tlb_entry_mask_in) & {keep, 2'h3}))
      else $error("entry copy");
   hwr_grant_a: assert property (hwr_rd_en_in &&
      hwr_index_in == TPM_USER_LOCAL_INDEX && (!user_mode_in || hw_read_enable_reg_in[29])
      |=> hwr_rd_ok_out) else $error("no grant");
   hwr_deny_a: assert property (hwr_rd_en_in && user_mode_in &&
      !hw_read_enable_reg_in[29] |=> !hwr_rd_ok_out && hwr_rd_data_out == 32'h0)
      else $error("user read leaked");
   spe_set_a: assert property (cop_wr_en_in && cop_sel_in == TPM_SEL_GRAIN &&
      cop_wr_data_in[28] |=> small_page_enable_out == (RELEASE2 && SMALL_PAGE_CAPABLE))
      else $error("small page enable wrong");
endmodule // tpm_regs_sva
bind tpm_regs tpm_regs_sva #(.SIZE_EN(SIZE_EN), .RELEASE2(RELEASE2),
   .SMALL_PAGE_CAPABLE(SMALL_PAGE_CAPABLE)) u_sva (.*);

// >>> dv/test_tpm_regs.sv
// test_tpm_regs: self-checking bench with a reference model of both registers.
// assumes tpm_regs with some page sizes left out of the build.
`timescale 1ns/10ps
module test_tpm_regs
   import tpm_pkg::*;
;
   localparam logic [7:0] SZ = 8'h5b;
   logic core_clk_in = 0, reset_n_in = 0, cop_wr_en_in = 0, hwr_rd_en_in = 0, user_mode_in = 0;
   logic tlb_read_en_in = 0, hwr_rd_ok_out, small_page_enable_out, m_spe = 0;
   logic [1:0] cop_sel_in = 0, m_mx = 0;
   logic [4:0] hwr_index_in = 0;
   logic [31:0] cop_wr_data_in = 0, hw_read_enable_reg_in = 0, cop_rd_data_out, hwr_rd_data_out;
   logic [17:0] tlb_entry_mask_in = 0, tlb_write_mask_out;
   logic [15:0] m_mask = 0, keep;
   logic [31:0] m_scr = 0, v;
   int n_mismatch = 0, checks = 0;
   always #20 core_clk_in = ~core_clk_in;
   tpm_regs #(.SIZE_EN(SZ)) u_dut (.*);
   function automatic logic [31:0] pm();
      return {3'h0, m_mask, m_spe ? m_mx : 2'h0, 11'h0};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [1:0] s, input logic [31:0] d);
      @(posedge core_clk_in) #1 {cop_wr_en_in, cop_sel_in, cop_wr_data_in} = {1'b1, s, d};
      @(posedge core_clk_in) #1 cop_wr_en_in = 0;
      if (s == TPM_SEL_SCRATCH) m_scr = d;
      if (s == TPM_SEL_GRAIN) m_spe = d[28];
      if (s == TPM_SEL_PMASK) m_mask = d[28:13] & keep;
      if (s == TPM_SEL_PMASK && m_spe) m_mx = d[12:11];
   endtask
   task automatic rd(input logic [1:0] s, input logic [31:0] exp);
      @(posedge core_clk_in) #1 cop_sel_in = s;
      @(posedge core_clk_in) #1 chk(cop_rd_data_out, exp);
      chk({14'h0, tlb_write_mask_out}, {14'h0, m_mask, m_spe ? m_mx : 2'h3});
   endtask
   task automatic hw(input logic [4:0] i, input logic u, input logic en);
      logic grant;
      @(posedge core_clk_in) #1 {hwr_rd_en_in, hwr_index_in, user_mode_in} = {1'b1, i, u};
      hw_read_enable_reg_in = {2'h0, en, 29'h0};
      @(posedge core_clk_in) #1 hwr_rd_en_in = 0;
      grant = i == TPM_USER_LOCAL_INDEX && (!u || en);
      chk({31'h0, hwr_rd_ok_out}, {31'h0, grant});
      chk(hwr_rd_data_out, grant ? m_scr : 32'h0);
   endtask
   task automatic finish_test();
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'hfac3));
      for (int g = 0; g < 8; g++) keep[2*g +: 2] = {2{SZ[g]}};
      repeat (2) @(posedge core_clk_in);
      #1 reset_n_in = 1;
      chk({14'h0, tlb_write_mask_out}, 32'h3);
      chk({31'h0, small_page_enable_out}, 32'h0);
      wr(TPM_SEL_PMASK, '1);
      rd(TPM_SEL_PMASK, pm());
      // no entries are held yet, so nothing needs flushing first
      wr(TPM_SEL_GRAIN, 32'h1000_0000);
      chk({31'h0, small_page_enable_out}, 32'h1);
      rd(TPM_SEL_GRAIN, {3'h0, m_spe, 28'h0});
      for (int s = 0; s < 9; s++) begin
         wr(TPM_SEL_PMASK, ((32'h1 << (2*s+2)) - 32'h1) << 11);
         rd(TPM_SEL_PMASK, pm());
      end
      $display("size encodings done");
      repeat (6) begin
         // entries only ever hold listed patterns, the all-zero 1 KB one included
         v = (32'h1 << (2 * ($urandom % 10))) - 32'h1;
         @(posedge core_clk_in) #1 {tlb_read_en_in, tlb_entry_mask_in} = {1'b1, v[17:0]};
         @(posedge core_clk_in) #1 tlb_read_en_in = 0;
         m_mask = tlb_entry_mask_in[17:2] & keep;
         m_mx = tlb_entry_mask_in[1:0];
         rd(TPM_SEL_PMASK, pm());
      end
      wr(TPM_SEL_GRAIN, 32'h0);
      wr(TPM_SEL_PMASK, 32'h0000_0800);
      rd(TPM_SEL_PMASK, pm());
      // the write above must not have reached the extension field
      wr(TPM_SEL_GRAIN, 32'h1000_0000);
      rd(TPM_SEL_PMASK, pm());
      $display("entry staging done");
      v = $urandom;
      wr(TPM_SEL_SCRATCH, v);
      rd(TPM_SEL_SCRATCH, v);
      for (int k = 0; k < 8; k++) begin
         hw(k[2] ? 5'h1e : TPM_USER_LOCAL_INDEX, k[0], k[1]);
      end
      $display("scratch and user read done");
      finish_test();
   end
   initial begin
      #1000000 n_mismatch++;
      finish_test();
   end
endmodule // test_tpm_regs
